/* rtl/psfc_cfg.svh */
/*
  Constants of the power stage fault-clear controller: register offsets,
  field positions, reset values and widths.
  Assumes it is included by its bare name from the package and the design.
*/
`ifndef PSFC_CFG_SVH
`define PSFC_CFG_SVH

`define PSFC_ADDR_W        4
`define PSFC_DATA_W        32
`define PSFC_CNT_W         8

`define PSFC_OFF_CTRL      4'h0
`define PSFC_OFF_PERIOD    4'h4
`define PSFC_OFF_DUTY      4'h8
`define PSFC_OFF_STATUS    4'hC
`define PSFC_OFF_INT_STAT  4'h1
`define PSFC_OFF_INT_MASK  4'h2

`define PSFC_CTRL_SRE_BIT  0
`define PSFC_CTRL_MODE_LSB 1
`define PSFC_CTRL_START    3
`define PSFC_CTRL_STOP     4

`define PSFC_INT_FAULT     0
`define PSFC_INT_CLEARED   1
`define PSFC_INT_W         2

`define PSFC_RST_SRE       1'b1
`define PSFC_RST_MODE      2'h3
`define PSFC_RST_PERIOD    8'h28
`define PSFC_RST_DUTY      8'h0A
`define PSFC_RST_MASK      2'h0

`endif

/* rtl/psfc_ctrl.sv */
/*
  Controller driving a synchronous buck power stage: pulse line (three-state),
  sync_rect_enable, and the clearing handshake for fault_flag_out.
  Assumes fault_flag_in_i is synchronous to ref_clk_i and that the clear mode
  programmed in CTRL matches the stage's strap.
*/
// What the document requires
// [R1] Stage picks clear protocol from its strap: ground tri-state, rail both-low, open single-pulse.
// [R2] Stage outside fault: pulse high gives high side, low gives low side if enabled.
// [R3] Tri-state mode: release pulse line after the flag rises; stage clears if fault gone.
// [R4] Stage sets fault_flag_out and holds both switches off until cleared.
// [R5] Controller treats rising fault_flag_out as interrupt and starts the selected clearing.
// [R6] Both-low mode: after the flag, drive sync_rect_enable low and hold pulse low.
// [R7] Stage takes pulse and sync_rect_enable both low as clear request.
// [R8] Both-low mode: resume on start only if flag cleared, else keep both low.
// [R9] Single-pulse mode: controller takes no special action and keeps pulsing.
// [R10] Single-pulse mode: stage clears its latch on pulse falling edge after clean pulse.
// [R11] Stage latch rises with the fault condition with gate delay only.
// [R12] Stage latch falls on qualifying pulse falling edge with gate delay only.
// [R13] First complete clean pulse clears the flag for every fault type.
// [R14] At power-up the flag clears itself once undervoltage_lockout releases.
// [R15] Later undervoltage fault needs one complete clean pulse to clear.
// [R16] Near 155 C the stage shuts down, sets the flag, switch node floats.
// [R17] After cooling about 30 C the stage resumes following pulse and enable.
// [R18] Tri-state detect, fault and temperature trip are separate digital inputs in models.
`timescale 1ns/100ps
`include "psfc_cfg.svh"

module psfc_ctrl
  import psfc_pkg::*;
(
  input  wire logic                    ref_clk_i,      // 25 MHz system clock
  input  wire logic                    reset_n_i,      // async reset, active low
  input  wire logic [`PSFC_ADDR_W-1:0] addr_i,         // register address
  input  wire logic [`PSFC_DATA_W-1:0] wdata_i,        // write data
  input  wire logic                    wr_i,           // write strobe
  input  wire logic                    rd_i,           // read strobe
  output logic      [`PSFC_DATA_W-1:0] rdata_o,        // read data, cycle after rd_i
  output logic                         irq_o,          // level interrupt
  input  wire logic                    fault_flag_in_i, // fault_flag_out of the stage
  output logic                         pulse_o,        // pulse line level
  output logic                         pulse_oe_o,     // pulse line driven when high
  output logic                         sync_rect_enable_o // synchronous rectifier enable
);
  import psfc_pkg::*;

  psfc_state_e             state;
  psfc_state_e             next_state;
  psfc_mode_e              mode;
  logic                    sre_en;
  psfc_cnt_t               period;
  psfc_cnt_t               duty;
  logic [`PSFC_INT_W-1:0]  int_stat;
  logic [`PSFC_INT_W-1:0]  int_mask;
  logic [`PSFC_INT_W-1:0]  next_int_stat;
  logic                    fault_q;
  logic                    fault_rise;
  logic                    fault_fall;
  logic                    start_cmd;
  logic                    stop_cmd;
  logic                    pwm_high;

  function automatic logic hit(input logic [`PSFC_ADDR_W-1:0] a, input logic [`PSFC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  assign fault_rise = fault_flag_in_i && !fault_q;
  assign fault_fall = !fault_flag_in_i && fault_q;
  assign start_cmd  = wr_i && hit(addr_i, `PSFC_OFF_CTRL) && wdata_i[`PSFC_CTRL_START];
  assign stop_cmd   = wr_i && hit(addr_i, `PSFC_OFF_CTRL) && wdata_i[`PSFC_CTRL_STOP];

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_flag_in_i;
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sre_en   <= `PSFC_RST_SRE;
      mode     <= psfc_mode_e'(`PSFC_RST_MODE);
      period   <= `PSFC_RST_PERIOD;
      duty     <= `PSFC_RST_DUTY;
      int_mask <= `PSFC_RST_MASK;
    end else if (wr_i) begin
      if (hit(addr_i, `PSFC_OFF_CTRL)) begin
        sre_en <= wdata_i[`PSFC_CTRL_SRE_BIT];
        mode   <= psfc_mode_e'(wdata_i[`PSFC_CTRL_MODE_LSB +: 2]);
      end
      if (hit(addr_i, `PSFC_OFF_PERIOD)) begin
        period <= wdata_i[`PSFC_CNT_W-1:0];
      end
      if (hit(addr_i, `PSFC_OFF_DUTY)) begin
        duty <= wdata_i[`PSFC_CNT_W-1:0];
      end
      if (hit(addr_i, `PSFC_OFF_INT_MASK)) begin
        int_mask <= wdata_i[`PSFC_INT_W-1:0];
      end
    end
  end

  // handshake sequencer; a fault wins over any command in the same cycle, except stop in single-pulse and reserved modes
  always_comb begin
    next_state = state;
    unique case (state)
      PSFC_ST_IDLE: begin
        if (start_cmd && !fault_flag_in_i) begin  // R8
          next_state = PSFC_ST_RUN;
        end
      end
      PSFC_ST_RUN: begin
        if (fault_rise && mode == PSFC_MODE_HIZ) begin  // R5
          next_state = PSFC_ST_FAULT_HIZ;  // R3
        end else if (fault_rise && mode == PSFC_MODE_LOW) begin  // R5
          next_state = PSFC_ST_FAULT_LOW;  // R6
        end else if (stop_cmd) begin
          next_state = PSFC_ST_IDLE;
        end
        // single-pulse and reserved modes keep pulsing through a fault  R9
      end
      PSFC_ST_FAULT_HIZ: begin
        if (!fault_flag_in_i) begin  // R3
          next_state = PSFC_ST_IDLE;
        end
      end
      PSFC_ST_FAULT_LOW: begin
        if (!fault_flag_in_i) begin  // R8
          next_state = PSFC_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= PSFC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  psfc_pwm_gen u_pwm (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .enable_i  (state == PSFC_ST_RUN),
    .period_i  (period),
    .duty_i    (duty),
    .high_o    (pwm_high)
  );

  // pin drive per state
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_o            <= 1'b0;
      pulse_oe_o         <= 1'b1;
      sync_rect_enable_o <= 1'b0;
    end else begin
      unique case (state)
        PSFC_ST_RUN: begin
          pulse_o            <= pwm_high;
          pulse_oe_o         <= 1'b1;
          sync_rect_enable_o <= sre_en;
        end
        PSFC_ST_FAULT_HIZ: begin
          pulse_o            <= 1'b0;
          pulse_oe_o         <= 1'b0;  // R3
          sync_rect_enable_o <= sre_en;
        end
        PSFC_ST_FAULT_LOW: begin
          pulse_o            <= 1'b0;  // R6
          pulse_oe_o         <= 1'b1;
          sync_rect_enable_o <= 1'b0;  // R6
        end
        PSFC_ST_IDLE: begin
          pulse_o            <= 1'b0;
          pulse_oe_o         <= 1'b1;
          sync_rect_enable_o <= 1'b0;
        end
      endcase
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_comb begin
    next_int_stat = int_stat;
    if (wr_i && hit(addr_i, `PSFC_OFF_INT_STAT)) begin
      next_int_stat = int_stat & ~wdata_i[`PSFC_INT_W-1:0];
    end
    if (fault_rise) begin
      next_int_stat[`PSFC_INT_FAULT] = 1'b1;  // R5
    end
    if (fault_fall) begin
      next_int_stat[`PSFC_INT_CLEARED] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_stat <= 2'h0;
      irq_o    <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq_o    <= |(next_int_stat & int_mask);
    end
  end

  // read port; data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `PSFC_OFF_CTRL:     rdata_o <= {29'h0, mode, sre_en};
        `PSFC_OFF_PERIOD:   rdata_o <= {24'h0, period};
        `PSFC_OFF_DUTY:     rdata_o <= {24'h0, duty};
        `PSFC_OFF_STATUS:   rdata_o <= {29'h0, state, fault_flag_in_i};
        `PSFC_OFF_INT_STAT: rdata_o <= {30'h0, int_stat};
        `PSFC_OFF_INT_MASK: rdata_o <= {30'h0, int_mask};
        default:            rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  AST_HIZ_RELEASE: assert property (  // R3
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (state == PSFC_ST_RUN && fault_rise && mode == PSFC_MODE_HIZ) |=> ##1 !pulse_oe_o)
    else $error("pulse line not released after fault in tri-state mode");

  AST_FAULT_IRQ: assert property (  // R5
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (fault_rise && int_mask[`PSFC_INT_FAULT]) |=> (int_stat[`PSFC_INT_FAULT] && irq_o))
    else $error("fault rise did not raise interrupt");

  AST_BOTH_LOW: assert property (  // R6
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (state == PSFC_ST_FAULT_LOW) |=> (!sync_rect_enable_o && !pulse_o && pulse_oe_o))
    else $error("both-low clearing not driven");

  AST_NO_RESTART: assert property (  // R8
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (state != PSFC_ST_RUN && fault_flag_in_i) |=> state != PSFC_ST_RUN)
    else $error("switching resumed while flag set");

  AST_SINGLE_KEEPS: assert property (  // R9
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (state == PSFC_ST_RUN && mode == PSFC_MODE_SINGLE && !stop_cmd) |=> state == PSFC_ST_RUN)
    else $error("single-pulse mode stopped pulsing");

  COV_HIZ_CLEAR: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state == PSFC_ST_FAULT_HIZ ##1 state == PSFC_ST_IDLE);
  COV_LOW_CLEAR: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state == PSFC_ST_FAULT_LOW ##1 state == PSFC_ST_IDLE);
  COV_SINGLE_FAULT: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    state == PSFC_ST_RUN && mode == PSFC_MODE_SINGLE && fault_fall);

endmodule : psfc_ctrl

/* rtl/psfc_pkg.sv */
/*
  Types of the power stage fault-clear controller.
  Assumes psfc_cfg.svh is on the include path.
*/
`include "psfc_cfg.svh"

package psfc_pkg;

  typedef enum logic [1:0] {
    PSFC_MODE_RSVD   = 2'h0,
    PSFC_MODE_HIZ    = 2'h1,
    PSFC_MODE_LOW    = 2'h2,
    PSFC_MODE_SINGLE = 2'h3
  } psfc_mode_e;

  typedef enum logic [1:0] {
    PSFC_ST_IDLE      = 2'h0,
    PSFC_ST_RUN       = 2'h1,
    PSFC_ST_FAULT_HIZ = 2'h2,
    PSFC_ST_FAULT_LOW = 2'h3
  } psfc_state_e;

  typedef logic [`PSFC_CNT_W-1:0] psfc_cnt_t;

endpackage : psfc_pkg

/* rtl/psfc_pwm_gen.sv */
/*
  Pulse-width generator: counts 0..period-1, output high while count < duty.
  Assumes one clock; restarts at count zero whenever enable is low.
*/
`timescale 1ns/100ps

module psfc_pwm_gen
  import psfc_pkg::*;
(
  input  wire logic            ref_clk_i,  // system clock
  input  wire logic            reset_n_i,  // async reset, active low
  input  wire logic            enable_i,   // run the counter
  input  wire psfc_pkg::psfc_cnt_t period_i, // cycles per pulse period
  input  wire psfc_pkg::psfc_cnt_t duty_i,   // high cycles per period
  output logic                 high_o      // registered pulse level
);
  import psfc_pkg::*;

  psfc_cnt_t count;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 8'h00;
    end else if (!enable_i || (count >= period_i - 8'h01)) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_o <= 1'b0;
    end else begin
      high_o <= enable_i && (count < duty_i);
    end
  end

endmodule : psfc_pwm_gen

/* sim/psfc_stage_model.sv */
/*
  Behavioural power stage facing psfc_ctrl: fault latch, clear protocols, switches.
  Assumes the bench drives fault condition, thermal trip and undervoltage lockout as plain digital inputs.
*/
`timescale 1ns/100ps

module psfc_stage_model (
  input  wire logic       pulse_i,                // pulse line level
  input  wire logic       pulse_hiz_i,            // pulse line released
  input  wire logic       sync_rect_enable_i,     // low side permitted
  input  wire logic [1:0] strap_i,                // 0 ground, 1 rail, 2 open
  input  wire logic       fault_cond_i,           // over-current present
  input  wire logic       overtemp_i,             // thermal trip present
  input  wire logic       undervoltage_lockout_i, // supply below limit
  output logic            fault_flag_out_o,       // latched fault flag
  output logic            high_side_switch_o,     // high side on
  output logic            low_side_switch_o       // low side on
);
  logic powered_up;
  logic clean_high;
  wire  cond = fault_cond_i | overtemp_i | (undervoltage_lockout_i & powered_up);

  initial begin
    fault_flag_out_o = 1'b1;
    powered_up       = 1'b0;
    clean_high       = 1'b0;
  end
  // first release of lockout clears the flag with no pulse
  always @(negedge undervoltage_lockout_i) if (!powered_up) begin
    powered_up       = 1'b1;
    fault_flag_out_o = 1'b0;
  end
  always @* begin
    if (cond) begin
      fault_flag_out_o = 1'b1;
      clean_high       = 1'b0;
    end else if (powered_up && strap_i == 2'h0 && pulse_hiz_i) begin
      fault_flag_out_o = 1'b0;
    end else if (powered_up && strap_i == 2'h1 && !pulse_hiz_i && !pulse_i && !sync_rect_enable_i) begin
      fault_flag_out_o = 1'b0;
    end
  end
  always @(posedge pulse_i) clean_high = !cond && !pulse_hiz_i;
  always @(negedge pulse_i) if (strap_i == 2'h2 && clean_high && !cond) fault_flag_out_o = 1'b0;
  assign high_side_switch_o = !fault_flag_out_o && !overtemp_i && !pulse_hiz_i && pulse_i;
  assign low_side_switch_o  = !fault_flag_out_o && !overtemp_i && !pulse_hiz_i && !pulse_i && sync_rect_enable_i;
endmodule : psfc_stage_model

/* sim/test_psfc_ctrl.sv */
/*
  Self-checking bench of psfc_ctrl driving the behavioural power stage.
  Assumes psfc_cfg.svh on the include path and the stage model compiled first.
*/
`timescale 1ns/100ps
`include "psfc_cfg.svh"

module test_psfc_ctrl;
  import psfc_pkg::*;
  logic        ref_clk_i, reset_n_i, wr_i, rd_i, fault_flag_out, pulse, oe, sync_rect_enable, irq, hs, ls, ot, undervoltage_lockout, cond;
  logic [1:0]  strap, seen;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata;
  int          bad_count, check_count;

  psfc_ctrl psfc_ctrl_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .irq_o(irq), .fault_flag_in_i(fault_flag_out), .pulse_o(pulse),
    .pulse_oe_o(oe), .sync_rect_enable_o(sync_rect_enable));
  psfc_stage_model psfc_stage_model_i (.pulse_i(pulse), .pulse_hiz_i(!oe), .sync_rect_enable_i(sync_rect_enable),
    .strap_i(strap), .fault_cond_i(cond), .overtemp_i(ot), .undervoltage_lockout_i(undervoltage_lockout),
    .fault_flag_out_o(fault_flag_out), .high_side_switch_o(hs), .low_side_switch_o(ls));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd

  // bounded wait for the stage flag, sampled just after each edge
  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (fault_flag_out !== v && n < 200) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(fault_flag_out, v);
  endtask : wait_flag

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : settle

  task automatic t_reset;
    settle(1);
    chk({oe, pulse, sync_rect_enable, irq}, 32'h8);
    @(posedge ref_clk_i);
    undervoltage_lockout <= 1'b0;
    #1;
    chk(fault_flag_out, 0);
    rd(`PSFC_OFF_CTRL, 32'h7);
    rd(`PSFC_OFF_PERIOD, 32'h28);
    rd(`PSFC_OFF_DUTY, 32'h0A);
    rd(`PSFC_OFF_INT_MASK, 32'h0);
    rd(4'h3, 32'h0);
  endtask : t_reset

  task automatic t_hiz;
    int n;
    wr(`PSFC_OFF_INT_STAT, 32'h3);
    strap <= 2'h0;
    wr(`PSFC_OFF_INT_MASK, 32'h1);
    wr(`PSFC_OFF_CTRL, 32'h3);
    wr(`PSFC_OFF_CTRL, 32'hB);
    settle(10);
    n = 0;
    repeat (`PSFC_RST_PERIOD) begin
      settle(1);
      n += pulse;
      chk({hs, ls}, {30'h0, pulse, !pulse});
    end
    chk(n, `PSFC_RST_DUTY);
    @(posedge ref_clk_i);
    ot <= 1'b1;
    settle(4);
    chk({oe, irq}, 32'h1);
    chk({hs, ls, fault_flag_out}, 32'h1);
    @(posedge ref_clk_i);
    ot <= 1'b0;
    wait_flag(1'b0);
    settle(3);
    chk({oe, pulse}, 32'h2);
    rd(`PSFC_OFF_STATUS, 32'h0);
    rd(`PSFC_OFF_INT_STAT, 32'h3);
    wr(`PSFC_OFF_INT_STAT, 32'h3);
    rd(`PSFC_OFF_INT_STAT, 32'h0);
    chk(irq, 0);
  endtask : t_hiz

  task automatic t_low;
    strap <= 2'h1;
    wr(`PSFC_OFF_CTRL, 32'h5);
    wr(`PSFC_OFF_CTRL, 32'hD);
    repeat (30) @(posedge ref_clk_i);
    cond <= 1'b1;
    settle(4);
    chk({oe, pulse, sync_rect_enable, fault_flag_out}, 32'h9);
    wr(`PSFC_OFF_CTRL, 32'hD);
    rd(`PSFC_OFF_STATUS, 32'h7);
    @(posedge ref_clk_i);
    cond <= 1'b0;
    wait_flag(1'b0);
    settle(3);
    chk({pulse, sync_rect_enable}, 32'h0);
    rd(`PSFC_OFF_STATUS, 32'h0);
    wr(`PSFC_OFF_CTRL, 32'hD);
    settle(4);
    rd(`PSFC_OFF_STATUS, 32'h2);
    wr(`PSFC_OFF_CTRL, 32'h15);
    rd(`PSFC_OFF_STATUS, 32'h0);
  endtask : t_low

  task automatic t_single;
    strap <= 2'h2;
    wr(`PSFC_OFF_CTRL, 32'h7);
    wr(`PSFC_OFF_CTRL, 32'hF);
    repeat (20) @(posedge ref_clk_i);
    undervoltage_lockout <= 1'b1;
    settle(2);
    chk({hs, ls, fault_flag_out}, 32'h1);
    seen = 2'h0;
    repeat (45) begin
      settle(1);
      seen[pulse] = 1'b1;
    end
    chk(seen, 32'h3);
    @(posedge ref_clk_i);
    undervoltage_lockout <= 1'b0;
    #1;
    chk(fault_flag_out, 1);
    wait_flag(1'b0);
    chk(pulse, 0);
    wr(`PSFC_OFF_CTRL, 32'h1);
    rd(`PSFC_OFF_CTRL, 32'h1);
  endtask : t_single

  task automatic print_verdict;
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    bad_count++;
    print_verdict;
  end

  initial begin
    reset_n_i = 1'b0;
    {wr_i, rd_i, ot, cond} = 4'h0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    undervoltage_lockout = 1'b1;
    strap = 2'h2;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_reset;
    t_hiz;
    t_low;
    t_single;
    print_verdict;
  end
endmodule : test_psfc_ctrl
